// [rtl/asb_pkg.sv]
// Constants for the accelerometer sample buffer
package asb_pkg;
   localparam logic [7:0] ADDR_THRESH     = 8'h32;
   localparam logic [7:0] ADDR_MODE       = 8'h33;
   localparam logic [7:0] ADDR_LEVEL      = 8'h34;
   localparam logic [7:0] ADDR_TRIG       = 8'h35;
   localparam logic [7:0] ADDR_FLUSH      = 8'h36;
   localparam logic [7:0] ADDR_READ       = 8'h7f;
   localparam logic [7:0] THRESH_RESET    = 8'h00;
   localparam logic [7:0] MODE_RESET      = 8'h00;
   localparam int         ENABLE_BIT      = 7;
   localparam int         RES_BIT         = 6;
   localparam int         TRIG_FLAG_BIT   = 7;
   localparam logic [6:0] CAP_HI          = 7'h29;  // 41 sets
   localparam logic [6:0] CAP_LO          = 7'h54;  // 84 sets
   localparam logic [7:0] BYTES_HI        = 8'h06;
   localparam logic [7:0] BYTES_LO        = 8'h03;
   localparam int         DEPTH           = 84;
   localparam int         AW              = 7;
   typedef enum logic [1:0] {
      ASB_FIFO, ASB_STREAM, ASB_TRIGGER, ASB_LIFO
   } asb_mode_t;
endpackage

// [rtl/asb_mem.sv]
// Sample-set memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module asb_mem (
   input  wire logic        clk,    // System clock
   input  wire logic        we,     // Write strobe
   input  wire logic [6:0]  waddr,  // Write slot
   input  wire logic [47:0] wdata,  // Three-axis set
   input  wire logic [6:0]  raddr,  // Read slot
   output logic      [47:0] rdata   // Registered read set
);
   logic [47:0] mem [0:asb_pkg::DEPTH-1];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // asb_mem
`default_nettype wire

// [rtl/asb_buffer.sv]
// Accelerometer sample buffer with register port
// Overview of operation
// RULE1 - Threshold field sets watermark sample count
// RULE2 - Capacity 41 sets high, 84 low
// RULE3 - Trigger mode: threshold is pre-trigger count
// RULE4 - Control bit 7 enables buffer collection
// RULE5 - Control bit 6 selects 12-bit storage
// RULE6 - Bits 1:0 select fifo/stream/trigger/lifo
// RULE7 - Fifo mode stops storing when full
// RULE8 - Stream mode drops oldest set when full
// RULE9 - Lifo drops oldest, reads newest first
// RULE10 - Trigger keeps pre-samples then fills to full
// RULE11 - Level reports bytes, 6 or 3 per set
// RULE12 - Status bit 7 shows trigger seen
// RULE13 - Host reads trigger buffer only after event
// RULE14 - Any write to flush empties everything; the code still sets the trigger flag if a trigger arrives in the flush cycle
// RULE15 - Host drains whole sets with auto-increment
// RULE16 - No sample writes during burst reads
// RULE17 - Read data are two's complement
// RULE18 - Trigger and sample arrive as strobes
`timescale 1ns/1ns
`default_nettype none
module asb_buffer (
   input  wire logic        clk,          // 100 MHz clock
   input  wire logic        nrst,         // Async reset, active low
   input  wire logic        reg_wr,       // Register write strobe
   input  wire logic        reg_rd,       // Register read strobe, one byte
   input  wire logic [7:0]  reg_addr,     // Register address
   input  wire logic [7:0]  reg_wdata,    // Write data
   input  wire logic        burst_active, // Host auto-increment read in progress
   output logic      [7:0]  reg_rdata,    // Read data, registered
   input  wire logic        sample_stb,   // New three-axis sample
   input  wire logic [11:0] sample_x,     // X, two's complement
   input  wire logic [11:0] sample_y,     // Y, two's complement
   input  wire logic [11:0] sample_z,     // Z, two's complement
   input  wire logic        trigger_stb,  // Trigger event
   output logic             watermark     // Stored sets reached nonzero threshold, outside trigger mode
);
   logic [7:0] thresh_r, thresh_nxt, mode_r, mode_nxt, rdata_r, rdata_nxt;
   logic [6:0] head_r, head_nxt, count_r, count_nxt;
   logic [2:0] bsel_r, bsel_nxt;
   logic       trig_r, trig_nxt;
   logic       mem_we;
   logic [6:0] waddr, raddr, cap, oldest;
   logic [47:0] wset, rset;
   logic       trig_set;
   asb_pkg::asb_mode_t mode;
   logic enable, hires, full, do_store, pop, set_done;

   // Slot arithmetic modulo the physical depth
   function automatic logic [6:0] wrap_add(input logic [6:0] a, input logic [6:0] b);
      logic [7:0] s;
      s = {1'b0, a} + {1'b0, b};
      if (s >= 8'(asb_pkg::DEPTH)) s = s - 8'(asb_pkg::DEPTH);
      return s[6:0];
   endfunction

   assign enable = mode_r[asb_pkg::ENABLE_BIT];                          // see RULE4
   assign hires  = mode_r[asb_pkg::RES_BIT];                             // see RULE5
   assign mode   = asb_pkg::asb_mode_t'(mode_r[1:0]);                    // see RULE6
   assign cap    = hires ? asb_pkg::CAP_HI : asb_pkg::CAP_LO;            // see RULE2
   assign full   = (count_r >= cap);
   assign trig_set = (mode == asb_pkg::ASB_TRIGGER) && enable && trigger_stb;
   assign oldest = wrap_add(head_r, 7'(asb_pkg::DEPTH) - count_r);
   assign watermark = (mode != asb_pkg::ASB_TRIGGER) && (thresh_r[6:0] != 7'h00)
                      && (count_r >= thresh_r[6:0]);                     // see RULE1
   // Low resolution keeps the top 8 bits so sign is preserved
   assign wset = hires ? {4'h0, sample_z, 4'h0, sample_y, 4'h0, sample_x}
                       : {24'h0, sample_z[11:4], sample_y[11:4], sample_x[11:4]}; // see RULE17

   // Storage decision
   always_comb begin
      do_store = 1'b0;
      if (enable && sample_stb && !burst_active) begin                   // see RULE16, RULE18
         case (mode)
            asb_pkg::ASB_FIFO:    do_store = !full;                      // see RULE7
            asb_pkg::ASB_STREAM:  do_store = 1'b1;                       // see RULE8
            asb_pkg::ASB_LIFO:    do_store = 1'b1;                       // see RULE9
            // Before the event only the pre-trigger window is kept
            asb_pkg::ASB_TRIGGER: do_store = trig_r ? !full : 1'b1;      // see RULE10
            default:              do_store = 1'b0;
         endcase
      end
   end
   assign mem_we = do_store;
   assign waddr  = head_r;
   assign set_done = bsel_r == (hires ? 3'd5 : 3'd2);
   assign pop    = reg_rd && reg_addr == asb_pkg::ADDR_READ && count_r != 7'h00 && set_done;
   // Lifo reads newest; others read oldest
   assign raddr  = (mode == asb_pkg::ASB_LIFO) ? wrap_add(head_r, 7'(asb_pkg::DEPTH - 1))
                                               : oldest;                 // see RULE9

   asb_mem u_mem (
      .clk   (clk),
      .we    (mem_we),
      .waddr (waddr),
      .wdata (wset),
      .raddr (raddr),
      .rdata (rset)
   );

   always_comb begin
      thresh_nxt = thresh_r;
      mode_nxt   = mode_r;
      head_nxt   = head_r;
      count_nxt  = count_r;
      trig_nxt   = trig_r;
      bsel_nxt   = bsel_r;
      rdata_nxt  = rdata_r;
      if (reg_wr) begin
         case (reg_addr)
            asb_pkg::ADDR_THRESH: thresh_nxt = {1'b0, reg_wdata[6:0]};
            asb_pkg::ADDR_MODE:   mode_nxt = reg_wdata & 8'hc3;
            default: ;
         endcase
      end
      if (do_store) begin
         head_nxt = wrap_add(head_r, 7'h01);
         if (mode == asb_pkg::ASB_TRIGGER && !trig_r) begin
            // An oversized threshold must not grow the count past capacity
            if (count_r < thresh_r[6:0] && !full) count_nxt = count_r + 7'h01; // see RULE3, RULE2
         end else if (!full) begin
            count_nxt = count_r + 7'h01;
         end
      end
      if (reg_rd) begin
         case (reg_addr)
            asb_pkg::ADDR_THRESH: rdata_nxt = thresh_r;
            asb_pkg::ADDR_MODE:   rdata_nxt = mode_r;
            asb_pkg::ADDR_LEVEL:  rdata_nxt = 8'(count_r) * (hires ? asb_pkg::BYTES_HI
                                                                   : asb_pkg::BYTES_LO); // see RULE11
            asb_pkg::ADDR_TRIG:   rdata_nxt = {trig_r, 7'h00};            // see RULE12
            asb_pkg::ADDR_READ: begin                                    // see RULE15
               if (hires) rdata_nxt = bsel_r[0] ? {rset[bsel_r[2:1]*16+8 +: 4], 4'h0} & 8'hff
                                                : rset[bsel_r[2:1]*16 +: 8];
               else rdata_nxt = rset[bsel_r[1:0]*8 +: 8];
               bsel_nxt = set_done ? 3'd0 : bsel_r + 3'd1;
            end
            default:              rdata_nxt = 8'h00;
         endcase
      end
      if (pop) begin
         count_nxt = count_r - 7'h01;
         if (mode == asb_pkg::ASB_LIFO) head_nxt = wrap_add(head_r, 7'(asb_pkg::DEPTH - 1));
      end
      if (reg_wr && reg_addr == asb_pkg::ADDR_FLUSH) begin              // see RULE14
         count_nxt = 7'h00;
         trig_nxt  = 1'b0;
         bsel_nxt  = 3'd0;
      end
      // A trigger in the flush cycle still latches: the set wins
      if (trig_set) trig_nxt = 1'b1;                                     // see RULE12
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         thresh_r <= asb_pkg::THRESH_RESET;
         mode_r   <= asb_pkg::MODE_RESET;
         head_r   <= 7'h00;
         count_r  <= 7'h00;
         trig_r   <= 1'b0;
         bsel_r   <= 3'd0;
         rdata_r  <= 8'h00;
      end else begin
         thresh_r <= thresh_nxt;
         mode_r   <= mode_nxt;
         head_r   <= head_nxt;
         count_r  <= count_nxt;
         trig_r   <= trig_nxt;
         bsel_r   <= bsel_nxt;
         rdata_r  <= rdata_nxt;
      end
   end
   assign reg_rdata = rdata_r;

   property p_fifo_no_overfill;
      @(posedge clk) disable iff (!nrst)
      (mode == asb_pkg::ASB_FIFO && full) |-> !mem_we;
   endproperty
   a_fifo_no_overfill: assert property (p_fifo_no_overfill) else $error("fifo stored when full"); // see RULE7

   property p_cap_bound;
      @(posedge clk) disable iff (!nrst)
      (do_store && full && !pop && !(reg_wr && reg_addr == asb_pkg::ADDR_FLUSH)) |=> count_r == $past(count_r);
   endproperty
   a_cap_bound: assert property (p_cap_bound) else $error("count beyond capacity"); // see RULE2

   property p_flush;
      @(posedge clk) disable iff (!nrst)
      (reg_wr && reg_addr == asb_pkg::ADDR_FLUSH) |=> (count_r == 7'h00 && trig_r == $past(trig_set));
   endproperty
   a_flush: assert property (p_flush) else $error("flush did not empty"); // see RULE14

   property p_burst_hold;
      @(posedge clk) disable iff (!nrst)
      burst_active |-> !mem_we;
   endproperty
   a_burst_hold: assert property (p_burst_hold) else $error("write during burst"); // see RULE16

   property p_stream_store;
      @(posedge clk) disable iff (!nrst)
      (enable && sample_stb && !burst_active && mode == asb_pkg::ASB_STREAM) |=> head_r == wrap_add($past(head_r), 7'h01);
   endproperty
   a_stream_store: assert property (p_stream_store) else $error("stream sample lost"); // see RULE8

   property p_disabled;
      @(posedge clk) disable iff (!nrst)
      !enable |-> !mem_we;
   endproperty
   a_disabled: assert property (p_disabled) else $error("stored while disabled"); // see RULE4

   property p_trig_flag;
      @(posedge clk) disable iff (!nrst)
      trig_set |=> trig_r;
   endproperty
   a_trig_flag: assert property (p_trig_flag) else $error("trigger not flagged"); // see RULE12

   property p_pretrig;
      @(posedge clk) disable iff (!nrst)
      (mode == asb_pkg::ASB_TRIGGER && !trig_r && thresh_r[6:0] <= cap) |-> count_r <= thresh_r[6:0];
   endproperty
   a_pretrig: assert property (p_pretrig) else $error("pre-trigger count exceeded"); // see RULE3
endmodule // asb_buffer
`default_nettype wire

// [sim/asb_host.sv]
// Host model driving the buffer register port
`timescale 1ns/1ns
`default_nettype none
module asb_host (
   input  wire logic       clk,          // Clock
   output logic            reg_wr,       // Write strobe
   output logic            reg_rd,       // Read strobe
   output logic      [7:0] reg_addr,     // Address
   output logic      [7:0] reg_wdata,    // Write data
   output logic            burst_active  // Auto-increment read level
);
   initial begin
      {reg_wr, reg_rd, burst_active} = 3'h0;
      {reg_addr, reg_wdata} = 16'h0000;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
   endtask
   // Whole sets only, then an idle cycle for the registered memory read
   task automatic set_rd(input int n);
      burst_active <= 1'h1;
      repeat (n) rd(8'h7f);
      burst_active <= 1'h0;
      @(posedge clk);
   endtask
endmodule // asb_host
`default_nettype wire

// [sim/tb_accel_sample_buffer.sv]
// Self-checking bench for the sample buffer
`timescale 1ns/1ns
`default_nettype none
module tb_accel_sample_buffer;
   logic        clk, nrst, stb, trg, rd_d, en, res, trig;
   logic        reg_wr, reg_rd, burst_active, watermark;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, th;
   logic [11:0] sx, sy, sz;
   logic [1:0]  md;
   logic [35:0] mq[$];
   logic [7:0]  exp_q[$];
   int          bad_count, compares, cyc;
   asb_host host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
                    .reg_wdata(reg_wdata), .burst_active(burst_active));
   asb_buffer dut_u (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
                     .reg_wdata(reg_wdata), .burst_active(burst_active), .reg_rdata(reg_rdata),
                     .sample_stb(stb), .sample_x(sx), .sample_y(sy), .sample_z(sz),
                     .trigger_stb(trg), .watermark(watermark));
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("mismatches %0d compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Read data lands one cycle after the strobe
   always @(posedge clk) rd_d <= reg_rd;
   always @(negedge clk) if (rd_d === 1'h1) check(reg_rdata, exp_q.pop_front());
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host_u.rd(a);
   endtask
   task automatic setm(input logic [7:0] v);
      host_u.wr(8'h33, v);
      {en, res, md} = {v[7:6], v[1:0]};
      trig = 1'h0;
   endtask
   task automatic flush();
      host_u.wr(8'h36, 8'h5a);
      mq.delete();
      trig = 1'h0;
   endtask
   function automatic void store(input logic [35:0] v);
      int cap;
      cap = res ? int'(asb_pkg::CAP_HI) : int'(asb_pkg::CAP_LO);
      if (md == asb_pkg::ASB_TRIGGER && !trig) begin
         mq.push_back(v);
         if (mq.size() > th) void'(mq.pop_front());
      end else if (mq.size() < cap) mq.push_back(v);
      else if (md[0]) begin
         void'(mq.pop_front());
         mq.push_back(v);
      end
   endfunction
   task automatic push(input int n, input logic acc);
      logic [35:0] v;
      repeat (n) begin
         v = 36'({$urandom, $urandom});
         @(posedge clk);
         stb <= 1'h1;
         {sx, sy, sz} <= v;
         if (acc && en) store(v);
         @(posedge clk);
         stb <= 1'h0;
      end
   endtask
   task automatic rd_set();
      logic [35:0] v;
      logic [11:0] w;
      v = (md == asb_pkg::ASB_LIFO) ? mq.pop_back() : mq.pop_front();
      for (int i = 2; i >= 0; i--) begin
         w = v[i*12 +: 12];
         if (res) begin
            exp_q.push_back(w[7:0]);
            exp_q.push_back({w[11:8], 4'h0});
         end else exp_q.push_back(w[11:4]);
      end
      host_u.set_rd(res ? 6 : 3);
   endtask
   task automatic lvl();
      rd(8'h34, 8'(mq.size() * (res ? 6 : 3)));
   endtask
   initial begin
      {nrst, stb, trg, en, res, trig, md, th, sx, sy, sz} = '0;
      {bad_count, compares, cyc} = '0;
      void'($urandom(67));
      repeat (3) @(posedge clk);
      nrst <= 1'h1;
      rd(8'h32, 8'h00);
      rd(8'h33, 8'h00);
      rd(8'h35, 8'h00);
      rd(8'h40, 8'h00);
      push(2, 1'h1);
      lvl();
      host_u.wr(8'h32, 8'hff);
      rd(8'h32, 8'h7f);
      host_u.wr(8'h32, 8'h02);
      th = 8'h02;
      setm(8'hbc);
      rd(8'h33, 8'h80);
      push(1, 1'h1);
      #1 check({7'h0, watermark}, 8'h00);
      push(1, 1'h1);
      #1 check({7'h0, watermark}, 8'h01);
      push(88, 1'h1);
      lvl();
      rd_set();
      flush();
      lvl();
      setm(8'hc1);
      push(45, 1'h1);
      lvl();
      rd_set();
      fork
         rd_set();
         push(1, 1'h0);
      join
      lvl();
      flush();
      setm(8'h83);
      push(3, 1'h1);
      rd_set();
      flush();
      setm(8'h82);
      push(5, 1'h1);
      rd(8'h35, 8'h00);
      lvl();
      @(posedge clk) trg <= 1'h1;
      @(posedge clk) trg <= 1'h0;
      trig = 1'h1;
      rd(8'h35, 8'h80);
      push(85, 1'h1);
      lvl();
      rd_set();
      flush();
      rd(8'h35, 8'h00);
      repeat (4) @(posedge clk);
      report_and_stop();
   end
endmodule // tb_accel_sample_buffer
`default_nettype wire
